// *** hdl/tscd_decoder.sv ***
// Step command decoder with its AXI4-Lite register slave.
// Assumes step bytes are written by software into a 32-entry queue here.
`timescale 1ns/100ps
`default_nettype none
`include "tscd_regs.svh"
module tscd_decoder (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [15:0] trig_in,
  output logic [31:0] trig_out,
  output logic [15:0] step_irq,
  output logic [4:0] adc_ch0_positive_select,
  output tscd_pkg::tscd_ptr_t queue_pointer,
  output logic irq
);
  import tscd_pkg::*;

  tscd_byte_t queue_q [0:31];
  tscd_state_t state_q;
  tscd_ptr_t ptr_q;
  tscd_byte_t step_byte;
  logic [3:0] cmd;
  logic [3:0] opt;
  logic [4:0] arg;
  logic run_q;
  logic [15:0] loop_limit_a;
  logic [15:0] loop_limit_b;
  logic [15:0] loop_counter_a;
  logic [15:0] loop_counter_b;
  logic [31:0] adjust_value_reg;
  logic [31:0] hold_value_reg;
  logic [31:0] target_q [0:3];
  logic [2:0] stat_q;
  logic [2:0] mask_q;
  logic [15:0] rise;
  logic [15:0] fall;
  logic exec;
  logic edge_hit;
  logic done_ev;
  logic rsvd_ev;
  logic irq_ev;
  logic aw_q;
  logic w_q;
  logic [11:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic wr_fire;
  logic wr_ok;
  logic [4:0] wr_slot;

  tscd_edge u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .trig_in(trig_in),
    .rise(rise),
    .fall(fall)
  );

  function automatic logic [31:0] merge(input logic [31:0] old,
                                       input logic [31:0] nw,
                                       input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction : merge

  function automatic logic [4:0] slot_of(input logic [11:0] a);
    return a[6:2];
  endfunction : slot_of

  assign step_byte = queue_q[ptr_q];
  assign cmd = step_byte[7:4];
  assign opt = step_byte[3:0];
  assign arg = {cmd[0], opt};
  assign queue_pointer = ptr_q;
  assign exec = (state_q == TSCD_EXEC);
  // Wait target decided by the command still at the queue head
  assign edge_hit = (cmd == 4'h4) ? rise[opt] : fall[opt];

  // Sequencer state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= TSCD_IDLE;
    end else begin
      case (state_q)
        TSCD_IDLE: begin
          if (run_q) begin
            state_q <= TSCD_EXEC;
          end
        end
        TSCD_EXEC: begin
          if (!run_q) begin
            state_q <= TSCD_IDLE;
          end else if (cmd == 4'h4 || cmd == 4'h5) begin
            state_q <= TSCD_WAIT;
          end
        end
        TSCD_WAIT: begin
          if (!run_q) begin
            state_q <= TSCD_IDLE;
          end else if (edge_hit) begin
            state_q <= TSCD_EXEC;
          end
        end
        default: state_q <= TSCD_IDLE;
      endcase
    end
  end

  // Queue pointer; an edge completes a wait and moves the pointer in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr_q <= `TSCD_RST_PTR;
    end else if (exec && run_q) begin
      casez (cmd)
        4'b101?: ptr_q <= arg;
        4'b110?: begin
          if (loop_counter_a == loop_limit_a) begin
            ptr_q <= ptr_q + 5'h01;
          end else begin
            ptr_q <= arg;
          end
        end
        4'b111?: begin
          if (loop_counter_b == loop_limit_b) begin
            ptr_q <= ptr_q + 5'h01;
          end else begin
            ptr_q <= arg;
          end
        end
        4'b0100, 4'b0101: ptr_q <= ptr_q;
        default: ptr_q <= ptr_q + 5'h01;
      endcase
    end else if (state_q == TSCD_WAIT && run_q && edge_hit) begin
      ptr_q <= ptr_q + 5'h01;
    end
  end

  // Loop counters; software may preset them, steps win
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loop_counter_a <= 16'h0000;
      loop_counter_b <= 16'h0000;
    end else begin
      if (exec && run_q && cmd[3:1] == 3'b110 &&
          loop_counter_a != loop_limit_a) begin
        loop_counter_a <= loop_counter_a + 16'h0001;
      end else if (wr_ok && awaddr_q == `TSCD_OFF_COUNT_A) begin
        loop_counter_a <= wdata_q[15:0];
      end
      if (exec && run_q && cmd[3:1] == 3'b111 &&
          loop_counter_b != loop_limit_b) begin
        loop_counter_b <= loop_counter_b + 16'h0001;
      end else if (wr_ok && awaddr_q == `TSCD_OFF_COUNT_B) begin
        loop_counter_b <= wdata_q[15:0];
      end
    end
  end

  // Outputs driven by steps; pulses last one cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trig_out <= 32'h0000_0000;
      step_irq <= 16'h0000;
      adc_ch0_positive_select <= 5'h00;
    end else begin
      trig_out <= 32'h0000_0000;
      step_irq <= 16'h0000;
      if (exec && run_q) begin
        if (cmd[3:1] == 3'b001) begin
          adc_ch0_positive_select <= arg;
        end
        if (cmd == 4'h7) begin
          step_irq[opt] <= 1'b1;
        end
        if (cmd[3:1] == 3'b100) begin
          trig_out[arg] <= 1'b1;
        end
      end
    end
  end

  // Target registers; add options 0-3 pick a target, 4-15 are reserved
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        target_q[i] <= `TSCD_RST_WORD;
      end
    end else if (exec && run_q && cmd == 4'h1 && opt < 4'h4) begin
      target_q[opt[1:0]] <= target_q[opt[1:0]] + adjust_value_reg;
    end else if (exec && run_q && cmd == 4'h0 && opt[3:2] == 2'b01) begin
      target_q[opt[1:0]] <= hold_value_reg;
    end else if (exec && run_q && cmd == 4'h0 && opt[3:2] == 2'b10) begin
      target_q[opt[1:0]] <= `TSCD_RST_WORD;
    end else if (wr_ok && awaddr_q[11:4] == 8'h03) begin
      target_q[awaddr_q[3:2]] <= merge(target_q[awaddr_q[3:2]], wdata_q,
                                       wstrb_q);
    end
  end

  // Events: step done, reserved (no-op) step, interrupt step
  assign done_ev = exec && run_q && !(cmd == 4'h4 || cmd == 4'h5);
  assign rsvd_ev = exec && run_q && (cmd == 4'h6 ||
                   (cmd == 4'h0 && opt[3:2] == 2'b11) ||
                   (cmd == 4'h1 && opt >= 4'h4));
  assign irq_ev = exec && run_q && cmd == 4'h7;

  // Set wins over a write-one clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      stat_q <= 3'h0;
    end else begin
      stat_q <= (stat_q & ~((wr_ok && awaddr_q == `TSCD_OFF_IRQ_STAT) ?
                wdata_q[2:0] : 3'h0)) | {irq_ev, rsvd_ev, done_ev};
    end
  end
  assign irq = |(stat_q & mask_q);

  // AXI4-Lite write side
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready = !w_q && !s_axi_bvalid;
  assign wr_fire = aw_q && w_q && !s_axi_bvalid;
  assign wr_ok = wr_fire;
  assign wr_slot = slot_of(awaddr_q);
  assign s_axi_bresp = 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_q <= 1'b0;
      w_q <= 1'b0;
      awaddr_q <= 12'h000;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_q <= 1'b1;
        awaddr_q <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_q <= 1'b0;
        w_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Control and parameter registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      run_q <= 1'b0;
      mask_q <= 3'h0;
      loop_limit_a <= 16'h0000;
      loop_limit_b <= 16'h0000;
      adjust_value_reg <= `TSCD_RST_WORD;
      hold_value_reg <= `TSCD_RST_WORD;
    end else if (wr_ok) begin
      case (awaddr_q)
        `TSCD_OFF_CTRL: run_q <= wdata_q[`TSCD_CTRL_RUN_BIT];
        `TSCD_OFF_IRQ_MASK: mask_q <= wdata_q[2:0];
        `TSCD_OFF_LIMIT_A: loop_limit_a <= wdata_q[15:0];
        `TSCD_OFF_LIMIT_B: loop_limit_b <= wdata_q[15:0];
        `TSCD_OFF_ADJUST: adjust_value_reg <= merge(adjust_value_reg,
                                                    wdata_q, wstrb_q);
        `TSCD_OFF_HOLD: hold_value_reg <= merge(hold_value_reg, wdata_q,
                                                wstrb_q);
        default: run_q <= run_q;
      endcase
    end
  end

  // Step queue: 32 bytes, four to a word from 0x100 upward
  always_ff @(posedge aclk) begin
    if (wr_ok && awaddr_q[11:8] == 4'h1 && wr_slot[4:3] == 2'b00) begin
      for (int i = 0; i < 4; i++) begin
        if (wstrb_q[i]) begin
          queue_q[{wr_slot[2:0], 2'(i)}] <= wdata_q[i*8 +: 8];
        end
      end
    end
  end

  // AXI4-Lite read side; unmapped reads return zero with OKAY
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp = 2'b00;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      case ({s_axi_araddr[11:2], 2'b00})
        `TSCD_OFF_CTRL: s_axi_rdata <= {31'h0, run_q};
        `TSCD_OFF_STATUS: s_axi_rdata <= {25'h0, state_q, ptr_q};
        `TSCD_OFF_IRQ_STAT: s_axi_rdata <= {29'h0, stat_q};
        `TSCD_OFF_IRQ_MASK: s_axi_rdata <= {29'h0, mask_q};
        `TSCD_OFF_STEP: s_axi_rdata <= {24'h0, step_byte};
        `TSCD_OFF_LIMIT_A: s_axi_rdata <= {16'h0, loop_limit_a};
        `TSCD_OFF_LIMIT_B: s_axi_rdata <= {16'h0, loop_limit_b};
        `TSCD_OFF_ADJUST: s_axi_rdata <= adjust_value_reg;
        `TSCD_OFF_HOLD: s_axi_rdata <= hold_value_reg;
        `TSCD_OFF_COUNT_A: s_axi_rdata <= {16'h0, loop_counter_a};
        `TSCD_OFF_COUNT_B: s_axi_rdata <= {16'h0, loop_counter_b};
        `TSCD_OFF_TARGET0: s_axi_rdata <= target_q[0];
        `TSCD_OFF_TARGET1: s_axi_rdata <= target_q[1];
        `TSCD_OFF_TARGET2: s_axi_rdata <= target_q[2];
        `TSCD_OFF_TARGET3: s_axi_rdata <= target_q[3];
        default: s_axi_rdata <= 32'h0000_0000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule : tscd_decoder
`default_nettype wire

// *** hdl/tscd_regs.svh ***
// Register offsets, field positions and reset values of the step decoder.
// Assumes inclusion by the main file only.
`ifndef TSCD_REGS_SVH
`define TSCD_REGS_SVH
`define TSCD_OFF_CTRL 12'h000
`define TSCD_OFF_STATUS 12'h004
`define TSCD_OFF_IRQ_STAT 12'h008
`define TSCD_OFF_IRQ_MASK 12'h00C
`define TSCD_OFF_STEP 12'h010
`define TSCD_OFF_LIMIT_A 12'h014
`define TSCD_OFF_LIMIT_B 12'h018
`define TSCD_OFF_ADJUST 12'h01C
`define TSCD_OFF_HOLD 12'h020
`define TSCD_OFF_COUNT_A 12'h024
`define TSCD_OFF_COUNT_B 12'h028
`define TSCD_OFF_TARGET0 12'h030
`define TSCD_OFF_TARGET1 12'h034
`define TSCD_OFF_TARGET2 12'h038
`define TSCD_OFF_TARGET3 12'h03C
`define TSCD_CTRL_RUN_BIT 0
`define TSCD_ST_STEP_DONE 0
`define TSCD_ST_RESERVED 1
`define TSCD_ST_IRQ 2
`define TSCD_RST_WORD 32'h0000_0000
`define TSCD_RST_PTR 5'h00
`endif

// *** hdl/tscd_pkg.sv ***
// Types shared by the step decoder and its register slave.
// Assumes nothing of its surroundings.
package tscd_pkg;
  typedef enum logic [1:0] {
    TSCD_IDLE = 2'b00,
    TSCD_EXEC = 2'b01,
    TSCD_WAIT = 2'b10
  } tscd_state_t;
  typedef logic [7:0] tscd_byte_t;
  typedef logic [4:0] tscd_ptr_t;
endpackage : tscd_pkg

// *** hdl/tscd_edge.sv ***
// Two-stage synchroniser and edge finder for the sixteen trigger inputs.
// Assumes the inputs are asynchronous to aclk.
`timescale 1ns/100ps
`default_nettype none
module tscd_edge (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [15:0] trig_in,
  output logic [15:0] rise,
  output logic [15:0] fall
);
  logic [15:0] meta_q;
  logic [15:0] sync_q;
  logic [15:0] last_q;

  // First stage read only by the second
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 16'h0000;
      sync_q <= 16'h0000;
      last_q <= 16'h0000;
    end else begin
      meta_q <= trig_in;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule : tscd_edge
`default_nettype wire

// *** tb/tscd_props.sv ***
// Port checker for the step decoder.
// Assumes one clock domain; bound into tscd_decoder below.
`timescale 1ns/100ps
`default_nettype none
module tscd_props (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] trig_out,
  input wire logic [15:0] step_irq,
  input wire tscd_pkg::tscd_ptr_t queue_pointer
);
  import tscd_pkg::*;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  a_trig_onehot: assert property (
    trig_out != 0 |-> $onehot(trig_out)) else $error("trigger not one-hot");
  a_irq_onehot: assert property (
    step_irq != 0 |-> $onehot(step_irq)) else $error("irq not one-hot");
  a_one_step: assert property (
    trig_out == 0 || step_irq == 0) else $error("two steps in one cycle");
  a_reset_clear: assert property (
    $rose(aresetn) |-> queue_pointer == 0 && trig_out == 0)
    else $error("outputs not clear after reset");
  // Both items are latched first, the response follows one cycle later
  a_b_after: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_r_after: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  a_ar_refuse: assert property (
    s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_aw_refuse: assert property (s_axi_bvalid |->
    !s_axi_awready && !s_axi_wready) else $error("write taken while busy");
  c_trig: cover property (trig_out != 0);
  c_irq: cover property (step_irq != 0);
  c_jump: cover property (queue_pointer < $past(queue_pointer));
endmodule : tscd_props
bind tscd_decoder tscd_props u_tscd_props (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .trig_out, .step_irq, .queue_pointer
);
`default_nettype wire

// *** tb/tscd_periph_model.sv ***
// Peripheral side: drives trigger lines, collects pulses it receives.
// Assumes the decoder outputs are registered to aclk.
`timescale 1ns/100ps
`default_nettype none
module tscd_periph_model (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] trig_out,
  input wire logic [15:0] step_irq,
  output var logic [15:0] trig_in,
  output var logic [31:0] trig_seen,
  output var logic [15:0] irq_seen
);
  initial trig_in = 16'h0000;
  // Collect every line ever pulsed, so a stray step shows up
  always @(posedge aclk) begin
    if (!aresetn) begin
      trig_seen <= 32'h0;
      irq_seen <= 16'h0;
    end else begin
      trig_seen <= trig_seen | trig_out;
      irq_seen <= irq_seen | step_irq;
    end
  end
  task automatic drive(input int i, input logic v);
    @(posedge aclk);
    trig_in[i] <= v;
  endtask : drive
endmodule : tscd_periph_model
`default_nettype wire

// *** tb/trigger_step_command_decoder_bench.sv ***
// Bench: loads a step program, runs it, checks the ports.
// Assumes the checker binds itself and the model is compiled.
`timescale 1ns/100ps
`default_nettype none
module trigger_step_command_decoder_bench;
  import tscd_pkg::*;
  logic aclk, irq, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, trig_out, trig_seen;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [15:0] trig_in, step_irq, irq_seen;
  logic [4:0] adc_ch0_positive_select;
  tscd_ptr_t queue_pointer;
  int miscompares = 0;
  int n_compared = 0;
  tscd_decoder u_tscd_decoder (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .trig_in, .trig_out, .step_irq,
    .adc_ch0_positive_select, .queue_pointer, .irq
  );
  tscd_periph_model u_tscd_periph_model (
    .aclk, .aresetn, .trig_out, .step_irq, .trig_in, .trig_seen, .irq_seen
  );
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic summarize;
    $display("compared %0d, mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : summarize
  // Ready lines are low while bvalid is high, so no strobe is lowered and raised in one step
  task automatic axw(input logic [11:0] a, input logic [31:0] d);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    chk(32'(s_axi_bresp), 32'h0);
  endtask : axw
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    chk(s_axi_rdata, exp);
    chk(32'(s_axi_rresp), 32'h0);
  endtask : rchk
  task automatic wait_ptr(input tscd_ptr_t p);
    for (int k = 0; k < 300 && queue_pointer !== p; k++) @(posedge aclk);
    chk(32'(queue_pointer), 32'(p));
  endtask : wait_ptr
  // Steps: select, pulse, irq, nop, waits, loops, copy, add, jumps
  task automatic t_setup;
    chk(32'(queue_pointer), 32'h0);
    chk(32'(adc_ch0_positive_select), 32'h0);
    rchk(12'h0FC, 32'h0);
    axw(12'h100, 32'h6072_9335);
    axw(12'h104, 32'hE7C6_5141);
    axw(12'h108, 32'h94AC_1004);
    axw(12'h10C, 32'h0000_00AC);
    axw(12'h014, 32'h1);
    axw(12'h01C, 32'h11);
    axw(12'h020, 32'h100);
    $display("test setup done");
  endtask : t_setup
  task automatic t_waits;
    axw(12'h000, 32'h1);
    wait_ptr(5'h04);
    repeat (6) @(posedge aclk);
    chk(32'(queue_pointer), 32'h4);
    u_tscd_periph_model.drive(1, 1'b1);
    wait_ptr(5'h05);
    repeat (6) @(posedge aclk);
    chk(32'(queue_pointer), 32'h5);
    u_tscd_periph_model.drive(1, 1'b0);
    wait_ptr(5'h0C);
    $display("test waits done");
  endtask : t_waits
  task automatic t_result;
    repeat (4) @(posedge aclk);
    chk(32'(queue_pointer), 32'hC);
    chk(32'(adc_ch0_positive_select), 32'h15);
    chk(trig_seen, 32'h0008_0000);
    chk(32'(irq_seen), 32'h4);
    rchk(12'h030, 32'h111);
    rchk(12'h024, 32'h1);
    rchk(12'h028, 32'h0);
    rchk(12'h008, 32'h7);
    chk(32'(irq), 32'h0);
    axw(12'h00C, 32'h4);
    chk(32'(irq), 32'h1);
    axw(12'h008, 32'h4);
    chk(32'(irq), 32'h0);
    axw(12'h000, 32'h0);
    $display("test result done");
  endtask : t_result
  // Steps 12-15: clear target 0, reserved control, reserved add, jump self
  task automatic t_ctrl;
    axw(12'h10C, 32'hAF15_0D08);
    axw(12'h008, 32'h7);
    axw(12'h000, 32'h1);
    wait_ptr(5'h0F);
    repeat (4) @(posedge aclk);
    chk(32'(queue_pointer), 32'hF);
    rchk(12'h030, 32'h0);
    rchk(12'h034, 32'h0);
    rchk(12'h008, 32'h3);
    rchk(12'h024, 32'h1);
    axw(12'h000, 32'h0);
    $display("test control done");
  endtask : t_ctrl
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_setup();
    t_waits();
    t_result();
    t_ctrl();
    summarize();
  end
  initial begin
    #40000;
    $display("MISMATCH %0t run did not finish", $time);
    miscompares++;
    summarize();
  end
endmodule : trigger_step_command_decoder_bench
`default_nettype wire
